/* design/phy_mgmt_pkg.sv */
// Constants shared by the management register block and its helpers.
// Assumes a 16-bit register word carried in the low half of a 32-bit AXI4-Lite data bus.
package phy_mgmt_pkg;

    // Register word width and bus answer codes.
    localparam int          REG_W        = 16;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Register indexes; the byte address is four times the index.
    localparam logic [4:0]  IDX_GP_PIN_LED   = 5'h0E;
    localparam logic [4:0]  IDX_MAC_TX       = 5'h14;
    localparam logic [4:0]  IDX_IRQ_ROUTE    = 5'h1B;
    localparam logic [4:0]  IDX_IRQ_ENABLE   = 5'h1C;
    localparam logic [4:0]  IDX_IRQ_PENDING  = 5'h1D;
    localparam logic [4:0]  IDX_PAGE         = 5'h1F;

    // Page select values.
    localparam logic [15:0] PAGE_MAIN  = 16'h0000;
    localparam logic [15:0] PAGE_EXT2  = 16'h0002;
    localparam logic [15:0] PAGE_GP    = 16'h0010;

    // Transmit control fields.
    localparam int          TX_REV_BIT  = 3;
    localparam int          TX_DLY_LSB  = 0;
    localparam int          TX_DLY_W    = 3;

    // Interrupt routing and interrupt source bit positions.
    localparam int          ROUTE_SPLIT_BIT  = 1;
    localparam int          IRQ_RX_FIFO_BIT  = 13;
    localparam int          IRQ_TX_FIFO_BIT  = 12;
    localparam int          IRQ_EEE_LSB      = 0;
    localparam int          IRQ_EEE_W        = 4;

    // General purpose pin and LED fields.
    localparam int          LP_DIR_BIT   = 13;
    localparam int          LP_OUT_BIT   = 12;
    localparam int          LP_IN_BIT    = 11;
    localparam int          LED_TRI_BIT  = 9;

    // Reset values.
    localparam logic [15:0] GP_PIN_LED_RST  = 16'h2200;
    localparam logic [15:0] MAC_TX_RST      = 16'h0000;
    localparam logic [15:0] IRQ_ROUTE_RST   = 16'h0000;
    localparam logic [15:0] IRQ_ENABLE_RST  = 16'h0000;
    localparam logic [15:0] IRQ_PEND_RST    = 16'h0000;

    // Bits that software may write in each register.
    localparam logic [15:0] GP_PIN_LED_WMASK  = 16'hF200;
    localparam logic [15:0] MAC_TX_WMASK      = 16'h000F;
    localparam logic [15:0] IRQ_ROUTE_WMASK   = 16'h0003;
    localparam logic [15:0] IRQ_ENABLE_WMASK  = 16'h300F;

    // Transmit clock skew per code, in picoseconds.
    localparam logic [11:0] TX_DLY_PS [8] = '{12'd200, 12'd800, 12'd1100, 12'd1700,
                                              12'd2000, 12'd2300, 12'd2600, 12'd3400};

endpackage

/* design/sync2.sv */
// Two flip-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level or is sampled again by later logic.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);
    // First stage; only the second stage reads it.
    logic [W-1:0] meta_q;

    // Both stages clear on reset so no unknown level escapes.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= '0;
            o_q    <= '0;
        end else begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule
`default_nettype wire

/* design/phy_mgmt_ext_ctrl_regs.sv */
// Management register block: transmit data reversal and clock skew, interrupt
// routing, interrupt enable and pending bits, page select and the general
// purpose pin and LED controls, all reached over AXI4-Lite.
// Assumes the MAC transmit pins and the pin levels arrive from outside the clock domain.
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - RGMII mode reverses the four transmit lines.
// - GMII/MII mode reverses all eight transmit lines.
// - Three-bit code selects transmit clock skew.
// - Routing clear merges both ports onto both pins.
// - Routing set keeps each port on own pin.
// - Enable bits 13 and 12 gate FIFO errors.
// - Enable bits 3 to 0 gate EEE events.
// - Pending bits 13 and 12 flag FIFO errors.
// - Pending bits 3 to 0 flag EEE events.
// - Page value 0x0010 selects general purpose space.
// - Page value 0x0000 returns to main page.
// - General purpose bits survive ordinary resets.
// - Reserved general purpose addresses have no effect.
// - Direction bit 13 sets pin input, reset input.
// - Output pin drives data bit 12.
// - Bit 11 reads the sampled pin level.
// - LED tristate bit floats high LED outputs.
module phy_mgmt_ext_ctrl_regs
    import phy_mgmt_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int LED_N  = 3
) (
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_por_n,
    // AXI4-Lite slave.
    input  wire logic [ADDR_W-1:0] i_awaddr,
    input  wire logic              i_awvalid,
    output logic                   o_awready,
    input  wire logic [31:0]       i_wdata,
    input  wire logic [3:0]        i_wstrb,
    input  wire logic              i_wvalid,
    output logic                   o_wready,
    output logic [1:0]             o_bresp,
    output logic                   o_bvalid,
    input  wire logic              i_bready,
    input  wire logic [ADDR_W-1:0] i_araddr,
    input  wire logic              i_arvalid,
    output logic                   o_arready,
    output logic [31:0]            o_rdata,
    output logic [1:0]             o_rresp,
    output logic                   o_rvalid,
    input  wire logic              i_rready,
    // MAC transmit side and mode strap.
    input  wire logic              i_tx_clk,
    input  wire logic [7:0]        i_txd,
    input  wire logic              i_rgmii_mode,
    output logic [7:0]             o_txd,
    output logic                   o_txd_strobe,
    output logic [11:0]            o_tx_clk_skew_ps,
    // Interrupt sources and pins.
    input  wire logic              i_rx_fifo_err,
    input  wire logic              i_tx_fifo_err,
    input  wire logic [3:0]        i_eee_evt,
    input  wire logic              i_port1_irq,
    output logic                   o_port0_irq_pin,
    output logic                   o_port1_irq_pin,
    output logic                   o_irq,
    // Low power hold pin, used as GPIO.
    input  wire logic              i_low_power_hold_pin,
    output logic                   o_low_power_hold_pin,
    output logic                   o_low_power_hold_pin_oe_n,
    // LEDs.
    input  wire logic [LED_N-1:0]  i_led_on,
    output logic [LED_N-1:0]       o_led,
    output logic [LED_N-1:0]       o_led_oe_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers.
    ////////////////////////////////////////////////////////////////////////////

    logic [1:0]  rst_sync_q;    // Ordinary reset release chain.
    logic [1:0]  por_sync_q;    // Power-on reset release chain.
    logic        rst_n;         // Ordinary reset used by the design.
    logic        por_n;         // Power-on reset, clears sticky state.
    logic [10:0] pins_s;        // Synchronised pin levels.
    logic        tx_clk_s;      // Synchronised transmit clock.
    logic [7:0]  txd_s;         // Synchronised transmit data.
    logic        rgmii_s;       // Synchronised mode strap.
    logic        lp_pin_s;      // Synchronised low power pin level.
    logic        tx_clk_d1_q;   // Previous transmit clock sample.

    // Reset is asserted at once and released two clock edges later.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    // Power-on release chain, kept apart from the ordinary reset.
    always_ff @(posedge i_ref_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            por_sync_q <= 2'h0;
        end else begin
            por_sync_q <= {por_sync_q[0], 1'b1};
        end
    end

    assign rst_n = rst_sync_q[1] & por_sync_q[1];
    assign por_n = por_sync_q[1];

    // Transmit clock, data, mode strap and low power pin levels pass two flip-flops before use.
    sync2 #(.W(11)) u_pin_sync (
        .i_clk   (i_ref_clk),
        .i_rst_n (rst_n),
        .i_d     ({i_low_power_hold_pin, i_rgmii_mode, i_txd, i_tx_clk}),
        .o_q     (pins_s)
    );

    assign tx_clk_s = pins_s[0];
    assign txd_s    = pins_s[8:1];
    assign rgmii_s  = pins_s[9];
    assign lp_pin_s = pins_s[10];

    ////////////////////////////////////////////////////////////////////////////
    // Register state.
    ////////////////////////////////////////////////////////////////////////////

    logic [15:0] gp_pin_led_q;          // General purpose pin and LED control.
    logic [15:0] mac_tx_q;              // Transmit reversal and skew.
    logic [15:0] irq_route_q;           // Interrupt pin routing.
    logic [15:0] irq_enable_q;          // Interrupt enables.
    logic [15:0] irq_pending_q;         // Sticky pending events.
    logic [15:0] page_q;                // Current page.
    logic [15:0] irq_events;            // Events of this cycle.
    logic        wr_fire;               // Register write happens now.
    logic [4:0]  wr_idx;                // Index of that write.
    logic [15:0] wr_data;               // Data of that write, low half of the held data.
    logic        rd_fire;               // Read address taken now.
    logic [4:0]  rd_idx;                // Index of that read.
    logic [15:0] rd_value;              // Read data for that index.
    logic [3:0]  wstrb_q;               // Held write strobes.

    // Combine byte strobes with the old value so untouched lanes keep their bits.
    function automatic logic [15:0] merge(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  strb,
                                          input logic [15:0] wmask);
        logic [15:0] lane;
        lane = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
        return (old_v & ~lane) | (new_v & lane);
    endfunction

    // Byte addresses below 32 words and word aligned are mapped.
    function automatic logic mapped(input logic [ADDR_W-1:0] addr);
        return (addr >> 7) == '0 && addr[1:0] == 2'h0;
    endfunction

    // Page register lives at the same index on every page.
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            page_q <= PAGE_MAIN;
        end else if (wr_fire && wr_idx == IDX_PAGE) begin
            page_q <= merge(page_q, wr_data, wstrb_q[1:0], 16'hFFFF);
        end
    end

    // General purpose space is cleared only by power-on, never by ordinary reset.
    always_ff @(posedge i_ref_clk or negedge por_n) begin
        if (!por_n) begin
            gp_pin_led_q <= GP_PIN_LED_RST;
        end else if (wr_fire && page_q == PAGE_GP && wr_idx == IDX_GP_PIN_LED) begin
            gp_pin_led_q <= merge(gp_pin_led_q, wr_data, wstrb_q[1:0],
                                  GP_PIN_LED_WMASK);
        end
    end

    // Sticky extended controls also survive ordinary reset.
    always_ff @(posedge i_ref_clk or negedge por_n) begin
        if (!por_n) begin
            mac_tx_q     <= MAC_TX_RST;
            irq_route_q  <= IRQ_ROUTE_RST;
            irq_enable_q <= IRQ_ENABLE_RST;
        end else if (wr_fire && page_q == PAGE_EXT2) begin
            if (wr_idx == IDX_MAC_TX) begin
                mac_tx_q <= merge(mac_tx_q, wr_data, wstrb_q[1:0], MAC_TX_WMASK);
            end else if (wr_idx == IDX_IRQ_ROUTE) begin
                irq_route_q <= merge(irq_route_q, wr_data, wstrb_q[1:0], IRQ_ROUTE_WMASK);
            end else if (wr_idx == IDX_IRQ_ENABLE) begin
                irq_enable_q <= merge(irq_enable_q, wr_data, wstrb_q[1:0],
                                      IRQ_ENABLE_WMASK);
            end
        end
    end

    // Events are placed at their pending bit positions.
    always_comb begin
        irq_events = 16'h0000;
        irq_events[IRQ_RX_FIFO_BIT] = i_rx_fifo_err;
        irq_events[IRQ_TX_FIFO_BIT] = i_tx_fifo_err;
        irq_events[IRQ_EEE_LSB +: IRQ_EEE_W] = i_eee_evt;
    end

    // Pending bits clear on a status read; an event in that cycle still lands.
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pending_q <= IRQ_PEND_RST;
        end else if (rd_fire && page_q == PAGE_EXT2 && rd_idx == IDX_IRQ_PENDING) begin
            irq_pending_q <= irq_events;
        end else begin
            irq_pending_q <= irq_pending_q | irq_events;
        end
    end

    // Read data for the decoded index; reserved and unknown places read zero.
    always_comb begin
        rd_value = 16'h0000;
        if (rd_idx == IDX_PAGE) begin
            rd_value = page_q;
        end else if (page_q == PAGE_GP && rd_idx == IDX_GP_PIN_LED) begin
            rd_value = gp_pin_led_q;
            rd_value[LP_IN_BIT] = lp_pin_s;
        end else if (page_q == PAGE_EXT2 && rd_idx == IDX_MAC_TX) begin
            rd_value = mac_tx_q;
        end else if (page_q == PAGE_EXT2 && rd_idx == IDX_IRQ_ROUTE) begin
            rd_value = irq_route_q;
        end else if (page_q == PAGE_EXT2 && rd_idx == IDX_IRQ_ENABLE) begin
            rd_value = irq_enable_q;
        end else if (page_q == PAGE_EXT2 && rd_idx == IDX_IRQ_PENDING) begin
            rd_value = irq_pending_q;
        end
        // Every other general purpose index is reserved and reads zero.
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave.
    ////////////////////////////////////////////////////////////////////////////

    logic [ADDR_W-1:0] awaddr_q;   // Held write address.
    logic [31:0]       wdata_q;    // Held write data.
    logic              aw_full_q;  // Write address held.
    logic              w_full_q;   // Write data held.

    assign wr_fire = aw_full_q && w_full_q && !o_bvalid && mapped(awaddr_q);
    assign wr_idx  = awaddr_q[6:2];
    assign wr_data = wdata_q[15:0];
    assign rd_fire = i_arvalid && o_arready;
    assign rd_idx  = i_araddr[6:2];

    // Address and data are taken in either order and held until the answer.
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            awaddr_q  <= '0;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            o_awready <= 1'b1;
            o_wready  <= 1'b1;
        end else begin
            if (i_awvalid && o_awready) begin
                awaddr_q  <= i_awaddr;
                aw_full_q <= 1'b1;
                o_awready <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                wdata_q  <= i_wdata;
                wstrb_q  <= i_wstrb;
                w_full_q <= 1'b1;
                o_wready <= 1'b0;
            end
            if (o_bvalid && i_bready) begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                o_awready <= 1'b1;
                o_wready  <= 1'b1;
            end
        end
    end

    // One write answer per pair; unmapped addresses get an error.
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_bvalid <= 1'b0;
            o_bresp  <= RESP_OKAY;
        end else if (aw_full_q && w_full_q && !o_bvalid) begin
            o_bvalid <= 1'b1;
            o_bresp  <= mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // Read answer one cycle after the address; a new address waits for it to drain.
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= 32'h0000_0000;
            o_rresp   <= RESP_OKAY;
        end else if (rd_fire) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= mapped(i_araddr) ? {16'h0000, rd_value} : 32'h0000_0000;
            o_rresp   <= mapped(i_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit data path.
    ////////////////////////////////////////////////////////////////////////////

    // Mirror a byte end to end, or only its low nibble when nibble is set.
    function automatic logic [7:0] mirror(input logic [7:0] v, input logic nibble);
        logic [7:0] r;
        r = v;
        if (nibble) begin
            r[3:0] = {v[0], v[1], v[2], v[3]};
        end else begin
            r = {v[0], v[1], v[2], v[3], v[4], v[5], v[6], v[7]};
        end
        return r;
    endfunction

    // Keep the last clock sample to find edges; the sample rate limits link speed.
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_clk_d1_q <= 1'b0;
        end else begin
            tx_clk_d1_q <= tx_clk_s;
        end
    end

    // RGMII moves a nibble on both edges, GMII/MII a byte on the rising edge.
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_txd        <= 8'h00;
            o_txd_strobe <= 1'b0;
        end else if ((tx_clk_s ^ tx_clk_d1_q) && (rgmii_s || tx_clk_s)) begin
            o_txd_strobe <= 1'b1;
            if (!mac_tx_q[TX_REV_BIT]) begin
                o_txd <= rgmii_s ? {4'h0, txd_s[3:0]} : txd_s;
            end else if (rgmii_s) begin
                o_txd <= mirror({4'h0, txd_s[3:0]}, 1'b1);
            end else begin
                o_txd <= mirror(txd_s, 1'b0);
            end
        end else begin
            o_txd_strobe <= 1'b0;
        end
    end

    // Skew request for the clock delay line.
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_tx_clk_skew_ps <= TX_DLY_PS[0];
        end else begin
            o_tx_clk_skew_ps <= TX_DLY_PS[mac_tx_q[TX_DLY_LSB +: TX_DLY_W]];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pins.
    ////////////////////////////////////////////////////////////////////////////

    logic port0_req;  // This port's enabled pending events.

    assign port0_req = |(irq_pending_q & irq_enable_q);

    // Routing picks merged or separate requests per pin.
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_port0_irq_pin <= 1'b0;
            o_port1_irq_pin <= 1'b0;
            o_irq           <= 1'b0;
        end else begin
            o_irq <= port0_req;
            if (irq_route_q[ROUTE_SPLIT_BIT]) begin
                o_port0_irq_pin <= port0_req;
                o_port1_irq_pin <= i_port1_irq;
            end else begin
                o_port0_irq_pin <= port0_req | i_port1_irq;
                o_port1_irq_pin <= port0_req | i_port1_irq;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Low power pin and LEDs.
    ////////////////////////////////////////////////////////////////////////////

    // The pin floats until software turns it to an output.
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_low_power_hold_pin      <= 1'b0;
            o_low_power_hold_pin_oe_n <= 1'b1;
            o_led                     <= '0;
            o_led_oe_n                <= '1;
        end else begin
            o_low_power_hold_pin_oe_n <= gp_pin_led_q[LP_DIR_BIT];
            o_low_power_hold_pin      <= gp_pin_led_q[LP_OUT_BIT];
            o_led <= i_led_on;
            // A high LED floats so an external pull-up can take it above the supply.
            o_led_oe_n <= gp_pin_led_q[LED_TRI_BIT] ? i_led_on : '0;
        end
    end

endmodule
`default_nettype wire

/* tb/mac_tx_model.sv */
// MAC transmit side model: drives the transmit clock and data lines.
// Assumes the bench calls send; the clock stands low between frames.
`timescale 1ns/1ps
`default_nettype none
module mac_tx_model (
    output logic       o_tx_clk,
    output logic [7:0] o_txd
);
    initial begin
        o_tx_clk = 1'h0;
        o_txd = 8'h00;
    end
    // One 160 ns period, offset 3 ns from the bench clock edges.
    // Released data shows its inverse, so stale data is never taken as new.
    task automatic send(input logic [7:0] lo, input logic [7:0] hi);
        #3 o_txd = lo;
        #40 o_tx_clk = 1'h1;
        #40 o_txd = hi;
        #40 o_tx_clk = 1'h0;
        #40 o_txd = ~hi;
    endtask
endmodule
`default_nettype wire

/* tb/phy_mgmt_chk.sv */
// Port checker: bus answers, skew codes, strobe, interrupt pin.
// Assumes binding to the block top; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module phy_mgmt_chk (
    input wire logic        i_ref_clk,
    input wire logic        i_rst_n,
    input wire logic        i_awvalid,
    input wire logic        o_awready,
    input wire logic        i_wvalid,
    input wire logic        o_wready,
    input wire logic        o_bvalid,
    input wire logic        i_bready,
    input wire logic        i_arvalid,
    input wire logic        o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic        o_rvalid,
    input wire logic        i_rready,
    input wire logic        o_txd_strobe,
    input wire logic [11:0] o_tx_clk_skew_ps,
    input wire logic        o_irq,
    input wire logic        o_port0_irq_pin
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    a_b_stands: assert property (o_bvalid && !i_bready |=> o_bvalid)
        else $error("bvalid dropped early");
    a_r_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read answer changed");
    a_wr_busy: assert property (o_bvalid |-> !o_awready && !o_wready)
        else $error("ready high during answer");
    a_b_after: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid)
        else $error("write answer late");
    a_r_after: assert property (i_arvalid && o_arready |=> o_rvalid && o_rdata[31:16] == 16'h0)
        else $error("bad read answer");
    a_skew_code: assert property (o_tx_clk_skew_ps inside {12'h0C8, 12'h320, 12'h44C,
        12'h6A4, 12'h7D0, 12'h8FC, 12'hA28, 12'hD48}) else $error("skew off table");
    a_strobe_once: assert property (o_txd_strobe |=> !o_txd_strobe [*4])
        else $error("strobe too long");
    a_irq_pin0: assert property (o_irq |-> o_port0_irq_pin)
        else $error("first pin misses request");
endmodule
bind phy_mgmt_ext_ctrl_regs phy_mgmt_chk chk_inst (.*);
`default_nettype wire

/* tb/testbench.sv */
// Bench: AXI4-Lite tasks and call sequences with expected values.
// Assumes the MAC model drives the link; the low power pin is resolved here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import phy_mgmt_pkg::*;
    logic i_ref_clk = 1'h0, i_rst_n = 1'h0, i_por_n = 1'h0, lp_ext = 1'h1, i_rgmii_mode = 1'h0;
    logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0, i_arvalid = 1'h0, i_rready = 1'h0;
    logic i_rx_fifo_err = 1'h0, i_tx_fifo_err = 1'h0, i_port1_irq = 1'h0, i_tx_clk;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00, i_txd, o_txd, last_txd;
    logic [3:0] i_wstrb = 4'h0, i_eee_evt = 4'h0;
    logic [31:0] i_wdata = 32'h0, o_rdata;
    logic [2:0] i_led_on = 3'h5, o_led, o_led_oe_n;
    logic [1:0] o_bresp, o_rresp, rsp;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_txd_strobe, o_irq;
    logic o_port0_irq_pin, o_port1_irq_pin, o_low_power_hold_pin, o_low_power_hold_pin_oe_n;
    logic [11:0] o_tx_clk_skew_ps;
    logic [15:0] rdv;
    wire logic i_low_power_hold_pin;
    int mismatches = 0, tests_run = 0;
    // The pin follows the block while it drives, else the outside level.
    assign i_low_power_hold_pin = o_low_power_hold_pin_oe_n ? lp_ext : o_low_power_hold_pin;
    always #4 i_ref_clk = ~i_ref_clk;
    // The strobe stands one cycle, so the byte is caught here.
    always @(posedge i_ref_clk) if (o_txd_strobe === 1'h1) last_txd <= o_txd;
    mac_tx_model mac_tx_model_inst (.o_tx_clk(i_tx_clk), .o_txd(i_txd));
    phy_mgmt_ext_ctrl_regs phy_mgmt_ext_ctrl_regs_inst (.*);
    task automatic cy(input int n);
        repeat (n) @(posedge i_ref_clk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Address and data go out together, each dropped once taken.
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        logic aw, w;
        aw = 1'h0;
        w = 1'h0;
        cy(1);
        {i_awaddr, i_wdata, i_wstrb} <= {a, 16'h0, d, 4'h3};
        {i_awvalid, i_wvalid, i_bready} <= 3'h7;
        while (!(aw && w)) begin
            cy(1);
            if (i_awvalid && o_awready === 1'h1) begin aw = 1'h1; i_awvalid <= 1'h0; end
            if (i_wvalid && o_wready === 1'h1) begin w = 1'h1; i_wvalid <= 1'h0; end
        end
        do cy(1); while (o_bvalid !== 1'h1);
        chk(o_bresp, a[7] ? RESP_SLVERR : RESP_OKAY);
        i_bready <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] a);
        cy(1);
        {i_araddr, i_arvalid, i_rready} <= {a, 2'h3};
        do cy(1); while (o_arready !== 1'h1);
        i_arvalid <= 1'h0;
        do cy(1); while (o_rvalid !== 1'h1);
        {i_rready, rdv, rsp} <= {1'h0, o_rdata[15:0], o_rresp};
        cy(1);
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        rd(a);
        chk(rdv, e);
        chk(rsp, RESP_OKAY);
    endtask
    // One-cycle event pulses: rx, tx, then the four low power events.
    task automatic pulse(input logic [5:0] ev);
        cy(1);
        {i_rx_fifo_err, i_tx_fifo_err, i_eee_evt} <= ev;
        cy(1);
        {i_rx_fifo_err, i_tx_fifo_err, i_eee_evt} <= 6'h00;
        cy(3);
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        #100000 mismatches++;
        stop_test;
    end
    initial begin
        cy(12);
        {i_rst_n, i_por_n} <= 2'h3;
        cy(4);
        rc(8'h7C, PAGE_MAIN); chk(o_tx_clk_skew_ps, 12'h0C8);
        chk(o_led_oe_n, i_led_on); chk(o_led, i_led_on);
        chk(o_low_power_hold_pin_oe_n, 1'h1);
        wr(8'h7C, PAGE_GP); rc(8'h38, 16'h2A00);
        wr(8'h00, 16'hFFFF); rc(8'h00, 16'h0000);
        rd(8'h80); chk(rsp, RESP_SLVERR); wr(8'h80, 16'h0000);
        lp_ext <= 1'h0; wr(8'h38, 16'h1000); cy(4);
        chk(o_low_power_hold_pin_oe_n, 1'h0); chk(o_low_power_hold_pin, 1'h1);
        chk(o_led_oe_n, 3'h0); rc(8'h38, 16'h1800);
        i_rst_n <= 1'h0; cy(3); i_rst_n <= 1'h1; cy(4);
        rc(8'h7C, PAGE_MAIN); rc(8'h38, 16'h0000);
        wr(8'h7C, PAGE_GP); rc(8'h38, 16'h1800);
        wr(8'h7C, PAGE_EXT2); rc(8'h70, 16'h0000); rc(8'h74, 16'h0000);
        for (int c = 0; c < 8; c++) begin
            wr(8'h50, 16'(c)); cy(3); chk(o_tx_clk_skew_ps, TX_DLY_PS[c]);
        end
        wr(8'h50, 16'h0008); i_rgmii_mode <= 1'h1;
        mac_tx_model_inst.send(8'h0A, 8'h03); cy(8); chk(last_txd, 8'h0C);
        i_rgmii_mode <= 1'h0;
        mac_tx_model_inst.send(8'h1E, 8'h1E); cy(8); chk(last_txd, 8'h78);
        wr(8'h50, 16'h0000);
        mac_tx_model_inst.send(8'h1E, 8'h1E); cy(8); chk(last_txd, 8'h1E);
        wr(8'h70, 16'h300F); pulse(6'h10); chk(o_irq, 1'h1);
        chk(o_port1_irq_pin, 1'h1); rc(8'h74, 16'h1000); cy(3);
        chk(o_irq, 1'h0); rc(8'h74, 16'h0000);
        wr(8'h70, 16'h2000); pulse(6'h10); chk(o_irq, 1'h0); rc(8'h74, 16'h1000);
        pulse(6'h20); chk(o_irq, 1'h1); rc(8'h74, 16'h2000);
        for (int k = 0; k < 4; k++) begin
            wr(8'h70, 16'(1 << k)); pulse(6'(1 << k)); chk(o_irq, 1'h1);
            rc(8'h74, 16'(1 << k));
        end
        wr(8'h6C, 16'h0002); i_port1_irq <= 1'h1; cy(3);
        chk(o_port0_irq_pin, 1'h0); chk(o_port1_irq_pin, 1'h1);
        wr(8'h6C, 16'h0000); cy(3); chk(o_port0_irq_pin, 1'h1);
        stop_test;
    end
endmodule
`default_nettype wire
